//--- logic/ptd_pkg.sv
// shared types and constants for the time-of-day accumulators
package ptd_pkg;

   // channel count and field widths
   localparam int TOD_CH = 4;
   localparam int SEC_W = 48;
   localparam int NS_W = 32;
   localparam int SUBNS_W = 8;
   localparam int INC_NS_W = 8;
   localparam int MOD_W = 16;

   // nanosecond roll-over: last legal value, first second carry
   localparam logic [NS_W-1:0] NS_LAST = 32'h3B9AC9FF;
   localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3B9ACA00;

   // reset values
   localparam logic [SEC_W-1:0] SEC_RST = 48'h0;
   localparam logic [NS_W-1:0] NS_RST = 32'h0;
   localparam logic [SUBNS_W-1:0] SUBNS_RST = 8'h0;
   localparam logic [MOD_W-1:0] MOD_RST = 16'h0;

   // load and latch take effect at the first clock edge after the request
   localparam int LOAD_LATENCY = 1;
   localparam int LATCH_LATENCY = 1;

   // accumulation mode of one channel
   typedef enum logic
   {
      PTD_MODE_TIME,
      PTD_MODE_CYCLE
   } ptd_mode_e;

   // eleven byte time image: seconds, nanoseconds, sub-nanoseconds
   typedef struct packed
   {
      logic [SEC_W-1:0] sec;
      logic [NS_W-1:0] ns;
      logic [SUBNS_W-1:0] subns;
   } ptd_time_s;

   // per-channel setup, held steady while the channel runs
   typedef struct packed
   {
      ptd_mode_e mode;
      logic [INC_NS_W-1:0] inc_ns;
      logic [SUBNS_W-1:0] inc_subns;
      logic [MOD_W-1:0] mod_num;
      logic [MOD_W-1:0] mod_den;
      logic sync_load_en;
   } ptd_cfg_s;

endpackage

//--- logic/ptd_tod_accum.sv
// four time-of-day accumulators in PTP format, with host load, latch and sync-pulse load
`timescale 1ns/10ps
`default_nettype none

module ptd_tod_accum
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,

   // fractional output divider ticks and per-channel setup
   input wire logic [ptd_pkg::TOD_CH-1:0] i_div_tick,
   input wire ptd_pkg::ptd_cfg_s [ptd_pkg::TOD_CH-1:0] i_cfg,

   // host load: image plus strobe on the top seconds byte write
   input wire ptd_pkg::ptd_time_s [ptd_pkg::TOD_CH-1:0] i_load_image,
   input wire logic [ptd_pkg::TOD_CH-1:0] i_load_msb_wr,

   // host latch: access to the word ahead of the image
   input wire logic [ptd_pkg::TOD_CH-1:0] i_latch_req,

   // external sync pulse, active edge is rising
   input wire logic [ptd_pkg::TOD_CH-1:0] i_sync_pulse,

   // running time, snapshot and one-second pulse
   output ptd_pkg::ptd_time_s [ptd_pkg::TOD_CH-1:0] o_time,
   output ptd_pkg::ptd_time_s [ptd_pkg::TOD_CH-1:0] o_snap,
   output logic [ptd_pkg::TOD_CH-1:0] o_snap_valid,
   output logic [ptd_pkg::TOD_CH-1:0] o_pps,
   output logic [ptd_pkg::TOD_CH-1:0] o_sync_loaded
);

   import ptd_pkg::*;

   genvar ch;

   // one accumulator per channel
   generate
      for (ch = 0; ch < TOD_CH; ch++)
      begin : g_ch
         ptd_time_s time_reg;
         ptd_time_s time_next;
         ptd_time_s step_time;
         logic [MOD_W-1:0] mod_reg;
         logic [MOD_W-1:0] mod_next;
         logic mod_carry;
         logic sec_carry;
         logic sync_prev_reg;
         logic sync_edge;
         logic load_now;
         ptd_time_s snap_reg;
         logic snap_valid_reg;
         logic pps_reg;
         logic sync_loaded_reg;

         // flexible modulus: remainder num/den sub-ns units per tick
         always_comb
         begin
            logic [MOD_W:0] mod_sum;
            mod_sum = {1'b0, mod_reg} + {1'b0, i_cfg[ch].mod_num};
            mod_carry = 1'b0;
            mod_next = mod_sum[MOD_W-1:0];
            if ((i_cfg[ch].mod_den != MOD_RST) && (mod_sum >= {1'b0, i_cfg[ch].mod_den}))
            begin
               mod_carry = 1'b1;
               mod_next = MOD_W'(mod_sum - {1'b0, i_cfg[ch].mod_den});
            end
         end

         always_ff @(posedge i_clk or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               mod_reg <= MOD_RST;
            end
            else if (load_now || (i_cfg[ch].mode == PTD_MODE_CYCLE))
            begin
               mod_reg <= MOD_RST;
            end
            else if (i_div_tick[ch])
            begin
               mod_reg <= mod_next;
            end
         end

         // one tick of advance, in either mode
         always_comb
         begin
            logic [SUBNS_W:0] sub_sum;
            logic [NS_W:0] ns_sum;
            sub_sum = '0;
            ns_sum = '0;
            step_time = time_reg;
            sec_carry = 1'b0;
            case (i_cfg[ch].mode)
               PTD_MODE_TIME:
               begin
                  // period added as whole ns plus sub-ns units, rates
                  sub_sum = {1'b0, time_reg.subns} + {1'b0, i_cfg[ch].inc_subns}
                     + {{SUBNS_W{1'b0}}, mod_carry};
                  ns_sum = {1'b0, time_reg.ns} + {{(NS_W-INC_NS_W+1){1'b0}}, i_cfg[ch].inc_ns}
                     + {{NS_W{1'b0}}, sub_sum[SUBNS_W]};
                  step_time.subns = sub_sum[SUBNS_W-1:0];
                  if (ns_sum >= {1'b0, NS_PER_SEC})
                  begin
                     step_time.ns = NS_W'(ns_sum - {1'b0, NS_PER_SEC});
                     sec_carry = 1'b1;
                  end
                  else
                  begin
                     step_time.ns = ns_sum[NS_W-1:0];
                  end
               end
               PTD_MODE_CYCLE:
               begin
                  // 80-bit counter: ns is the low word, seconds the high
                  step_time.subns = SUBNS_RST;
                  step_time.ns = time_reg.ns + 32'h1;
                  sec_carry = (time_reg.ns == 32'hFFFFFFFF);
               end
               default:
               begin
                  step_time = time_reg;
               end
            endcase
            if (sec_carry)
            begin
               step_time.sec = time_reg.sec + 48'h1;
            end
         end

         // sync pulse edge detect and load selection
         assign sync_edge = i_sync_pulse[ch] && !sync_prev_reg;
         assign load_now = i_load_msb_wr[ch] || (i_cfg[ch].sync_load_en && sync_edge);

         always_ff @(posedge i_clk or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               sync_prev_reg <= 1'b0;
            end
            else
            begin
               sync_prev_reg <= i_sync_pulse[ch];
            end
         end

         always_comb
         begin
            time_next = time_reg;
            if (load_now)
            begin
               time_next = i_load_image[ch];
               if (i_cfg[ch].mode == PTD_MODE_CYCLE)
               begin
                  time_next.subns = SUBNS_RST;
               end
            end
            else if (i_div_tick[ch])
            begin
               time_next = step_time;
            end
         end

         // accumulator state, zero is the PTP epoch
         always_ff @(posedge i_clk or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               time_reg <= '{sec: SEC_RST, ns: NS_RST, subns: SUBNS_RST};
            end
            else
            begin
               time_reg <= time_next;
            end
         end

         // host snapshot of the running value
         always_ff @(posedge i_clk or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               snap_reg <= '{sec: SEC_RST, ns: NS_RST, subns: SUBNS_RST};
               snap_valid_reg <= 1'b0;
            end
            else
            begin
               snap_valid_reg <= i_latch_req[ch];
               if (i_latch_req[ch])
               begin
                  snap_reg <= time_reg;
               end
            end
         end

         // one-second pulse on each seconds advance while running in time mode
         always_ff @(posedge i_clk or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               pps_reg <= 1'b0;
               sync_loaded_reg <= 1'b0;
            end
            else
            begin
               pps_reg <= !load_now && i_div_tick[ch] && sec_carry
                  && (i_cfg[ch].mode == PTD_MODE_TIME);
               sync_loaded_reg <= i_cfg[ch].sync_load_en && sync_edge;
            end
         end

         assign o_time[ch] = time_reg;
         assign o_snap[ch] = snap_reg;
         assign o_snap_valid[ch] = snap_valid_reg;
         assign o_pps[ch] = pps_reg;
         assign o_sync_loaded[ch] = sync_loaded_reg;
      end
   endgenerate

endmodule

`default_nettype wire

//--- test/ptd_host_model.sv
// host side: time image load and latch strobes
`timescale 1ns/10ps
`default_nettype none
module ptd_host_model
import ptd_pkg::*;
(
   // clock
   input wire logic i_clk,
   // load and latch requests
   output var ptd_time_s [TOD_CH-1:0] o_load_image,
   output var logic [TOD_CH-1:0] o_load_msb_wr,
   output var logic [TOD_CH-1:0] o_latch_req
);
   initial
   begin
      o_load_image = '0;
      o_load_msb_wr = '0;
      o_latch_req = '0;
   end
   task automatic set_image(input int ch, input ptd_time_s img);
      o_load_image[ch] <= img;
   endtask
   // image is scrambled once the top seconds byte write is over
   task automatic load(input int ch, input ptd_time_s img);
      @(posedge i_clk);
      o_load_image[ch] <= img;
      o_load_msb_wr[ch] <= 1'b1;
      @(posedge i_clk);
      o_load_msb_wr[ch] <= 1'b0;
      o_load_image[ch] <= ~img;
   endtask
   task automatic latch(input int ch);
      @(posedge i_clk);
      o_latch_req[ch] <= 1'b1;
      @(posedge i_clk);
      o_latch_req[ch] <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- test/ptd_tod_accum_props.sv
// assertions on the time-of-day accumulator ports
`timescale 1ns/10ps
`default_nettype none
module ptd_tod_accum_props
import ptd_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // block ports
   input wire logic [TOD_CH-1:0] i_div_tick,
   input wire ptd_cfg_s [TOD_CH-1:0] i_cfg,
   input wire ptd_time_s [TOD_CH-1:0] i_load_image,
   input wire logic [TOD_CH-1:0] i_load_msb_wr,
   input wire logic [TOD_CH-1:0] i_latch_req,
   input wire logic [TOD_CH-1:0] i_sync_pulse,
   input wire ptd_time_s [TOD_CH-1:0] o_time,
   input wire ptd_time_s [TOD_CH-1:0] o_snap,
   input wire logic [TOD_CH-1:0] o_snap_valid,
   input wire logic [TOD_CH-1:0] o_pps,
   input wire logic [TOD_CH-1:0] o_sync_loaded
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   AST_LOAD: assert property (i_load_msb_wr[0] && i_cfg[0].mode == PTD_MODE_TIME
      |=> o_time[0] == $past(i_load_image[0])) else $error("load image missed");
   AST_LATCH: assert property (i_latch_req[0]
      |=> o_snap_valid[0] && o_snap[0] == $past(o_time[0])) else $error("snapshot wrong");
   AST_SNAP_HOLD: assert property (!i_latch_req[0]
      |=> !o_snap_valid[0] && $stable(o_snap[0])) else $error("snapshot moved");
   AST_SYNC: assert property ($rose(i_sync_pulse[3]) && i_cfg[3].sync_load_en
      && !i_load_msb_wr[3] |=> o_sync_loaded[3] && o_time[3] == $past(i_load_image[3]))
      else $error("sync load missed");
   AST_CYCLE: assert property (i_div_tick[1] && !i_load_msb_wr[1]
      && i_cfg[1].mode == PTD_MODE_CYCLE && !i_cfg[1].sync_load_en
      |=> o_time[1].ns == $past(o_time[1].ns) + 32'h1 && o_time[1].subns == 8'h0)
      else $error("cycle count wrong");
   AST_NS_RANGE: assert property (o_time[0].ns <= NS_LAST) else $error("ns out of range");
   AST_PPS: assert property (o_pps[0]
      |-> o_time[0].sec == $past(o_time[0].sec) + 48'h1) else $error("pps wrong");
   AST_IDLE: assert property (!i_div_tick[0] && !i_load_msb_wr[0]
      |=> $stable(o_time[0])) else $error("time moved without tick");
endmodule
bind ptd_tod_accum ptd_tod_accum_props ptd_tod_accum_props_inst (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_div_tick(i_div_tick), .i_cfg(i_cfg), .i_load_image(i_load_image),
   .i_load_msb_wr(i_load_msb_wr), .i_latch_req(i_latch_req), .i_sync_pulse(i_sync_pulse),
   .o_time(o_time), .o_snap(o_snap), .o_snap_valid(o_snap_valid), .o_pps(o_pps),
   .o_sync_loaded(o_sync_loaded));
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the time-of-day accumulators
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ptd_pkg::*;
   logic i_clk;
   logic i_sys_rst;
   logic [TOD_CH-1:0] i_div_tick;
   logic [TOD_CH-1:0] i_sync_pulse;
   logic [TOD_CH-1:0] msb_wr;
   logic [TOD_CH-1:0] latch_req;
   logic [TOD_CH-1:0] o_snap_valid;
   logic [TOD_CH-1:0] o_pps;
   logic [TOD_CH-1:0] o_sync_loaded;
   ptd_cfg_s [TOD_CH-1:0] i_cfg;
   ptd_time_s [TOD_CH-1:0] image;
   ptd_time_s [TOD_CH-1:0] o_time;
   ptd_time_s [TOD_CH-1:0] o_snap;
   int err_count = 0;
   int samples_checked = 0;

   ptd_tod_accum ptd_tod_accum_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_div_tick(i_div_tick), .i_cfg(i_cfg), .i_load_image(image), .i_load_msb_wr(msb_wr),
      .i_latch_req(latch_req), .i_sync_pulse(i_sync_pulse), .o_time(o_time), .o_snap(o_snap),
      .o_snap_valid(o_snap_valid), .o_pps(o_pps), .o_sync_loaded(o_sync_loaded));
   ptd_host_model ptd_host_model_inst (.i_clk(i_clk), .o_load_image(image),
      .o_load_msb_wr(msb_wr), .o_latch_req(latch_req));

   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic chk_time(input ptd_time_s got, input ptd_time_s exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask

   task automatic tick(input logic [TOD_CH-1:0] m, input int n);
      repeat (n)
      begin
         @(posedge i_clk);
         i_div_tick <= m;
      end
      @(posedge i_clk);
      i_div_tick <= '0;
      #1;
   endtask

   task automatic test_wrap();
      ptd_host_model_inst.load(0, '{48'h1, NS_LAST - 32'h4, 8'h0});
      tick(4'h1, 1);
      chk_time(o_time[0], '{48'h2, 32'h0, 8'h0});
      chk_time(o_time[1], '0);
      // pulse is registered with the seconds advance and lasts one cycle
      chk_bit(o_pps[0], 1'b1);
      @(posedge i_clk);
      #1;
      chk_bit(o_pps[0], 1'b0);
   endtask

   task automatic test_cycle();
      ptd_host_model_inst.load(1, '{48'h7, 32'hFFFFFFFF, 8'hAB});
      tick(4'h2, 2);
      chk_time(o_time[1], '{48'h8, 32'h1, 8'h0});
      chk_bit(o_pps[1], 1'b0);
   endtask

   task automatic test_modulus();
      ptd_host_model_inst.load(2, '0);
      tick(4'h4, 3);
      chk_time(o_time[2], '{48'h0, 32'h4, 8'h81});
   endtask

   task automatic test_latch();
      ptd_host_model_inst.load(0, '{48'hA5A5, 32'h1234, 8'h5});
      ptd_host_model_inst.latch(0);
      #1;
      chk_time(o_snap[0], '{48'hA5A5, 32'h1234, 8'h5});
      chk_bit(o_snap_valid[0], 1'b1);
   endtask

   task automatic test_sync();
      @(posedge i_clk);
      ptd_host_model_inst.set_image(3, '{48'h3C, 32'h77, 8'h9});
      ptd_host_model_inst.set_image(0, '{48'h1, 32'h1, 8'h1});
      @(posedge i_clk);
      i_sync_pulse <= 4'h9;
      @(posedge i_clk);
      i_sync_pulse <= 4'h0;
      #1;
      chk_time(o_time[3], '{48'h3C, 32'h77, 8'h9});
      chk_bit(o_sync_loaded[3], 1'b1);
      chk_time(o_time[0], '{48'hA5A5, 32'h1234, 8'h5});
   endtask

   task automatic print_verdict();
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      i_sys_rst = 1'b1;
      i_div_tick = '0;
      i_sync_pulse = '0;
      i_cfg[0] = '{PTD_MODE_TIME, 8'h05, 8'h00, 16'h0000, 16'h0000, 1'b0};
      i_cfg[1] = '{PTD_MODE_CYCLE, 8'h00, 8'h00, 16'h0000, 16'h0000, 1'b0};
      i_cfg[2] = '{PTD_MODE_TIME, 8'h01, 8'h80, 16'h0001, 16'h0003, 1'b0};
      i_cfg[3] = '{PTD_MODE_TIME, 8'h05, 8'h00, 16'h0000, 16'h0000, 1'b1};
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      #1;
      for (int c = 0; c < TOD_CH; c++) chk_time(o_time[c], '0);
      test_wrap();
      test_cycle();
      test_modulus();
      test_latch();
      test_sync();
      print_verdict();
   end

   // cut a hang short
   initial
   begin
      #20000;
      err_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
